// [logic/cpcu_pkg.sv]
// Package for the card parameter command unit: register map, command codes,
// trip bit positions and the structs that travel to and from the card side.
// Assumes a 32-bit APB bus and a card controller with a request/answer port.
package cpcu_pkg;

  // Register byte offsets
  localparam logic [7:0] CPCU_OFS_COMMAND   = 8'h00;
  localparam logic [7:0] CPCU_OFS_LAST_LOAD = 8'h04;
  localparam logic [7:0] CPCU_OFS_HDR_SEL   = 8'h08;
  localparam logic [7:0] CPCU_OFS_FTYPE     = 8'h0c;
  localparam logic [7:0] CPCU_OFS_FVERSION  = 8'h10;
  localparam logic [7:0] CPCU_OFS_FCHKSUM   = 8'h14;
  localparam logic [7:0] CPCU_OFS_CLONE_SEL = 8'h18;
  localparam logic [7:0] CPCU_OFS_STATUS    = 8'h1c;
  localparam logic [7:0] CPCU_OFS_CONTROL   = 8'h20;

  // Reset values
  localparam logic [13:0] CPCU_RST_COMMAND = 14'h0000;
  localparam logic [9:0]  CPCU_RST_BLOCK   = 10'h000;
  localparam logic [2:0]  CPCU_RST_CLONE   = 3'h0;
  localparam logic [4:0]  CPCU_RST_TRIPS   = 5'h00;

  // Whole-value command codes and limits
  localparam logic [13:0] CPCU_CODE_ERASE_ALL = 14'h270f;  // 9999
  localparam logic [13:0] CPCU_CODE_SUPP_SET  = 14'h25c2;  // 9666
  localparam logic [13:0] CPCU_CODE_SUPP_CLR  = 14'h2553;  // 9555
  localparam logic [13:0] CPCU_CODE_RO_SET    = 14'h26a0;  // 9888
  localparam logic [13:0] CPCU_CODE_RO_CLR    = 14'h2631;  // 9777
  localparam logic [13:0] CPCU_CODE_MAX       = 14'h270f;  // 9999
  localparam int          CPCU_CLASS_STEP     = 1000;
  localparam logic [3:0]  CPCU_CLASS_WRITE    = 4'h4;
  localparam logic [3:0]  CPCU_CLASS_READ     = 4'h6;
  localparam logic [3:0]  CPCU_CLASS_ERASE    = 4'h7;
  localparam logic [3:0]  CPCU_CLASS_COMPARE  = 4'h8;
  localparam logic [9:0]  CPCU_BLOCK_MAX      = 10'h3e7;   // 999

  // Header field limits
  localparam logic [2:0]  CPCU_FTYPE_MAX   = 3'h6;
  localparam logic [13:0] CPCU_FVER_MAX    = 14'h270f;
  localparam logic [2:0]  CPCU_CLONE_READ  = 3'h1;
  localparam logic [2:0]  CPCU_CLONE_PROG  = 3'h2;
  localparam logic [2:0]  CPCU_CLONE_MAX   = 3'h4;

  // Trip bit positions in the status register
  localparam int CPCU_TRIP_CARD    = 0;
  localparam int CPCU_TRIP_COMPARE = 1;
  localparam int CPCU_TRIP_OPTION  = 2;
  localparam int CPCU_TRIP_RATING  = 3;
  localparam int CPCU_TRIP_RO      = 4;
  localparam int CPCU_TRIP_N       = 5;

  // Status and control bit positions
  localparam int CPCU_ST_RO      = 5;
  localparam int CPCU_ST_SUPP    = 6;
  localparam int CPCU_ST_BUSY    = 7;
  localparam int CPCU_ST_EMPTY   = 8;
  localparam int CPCU_CTL_RELOAD = 8;

  // Card operations
  typedef enum logic [2:0] {
    CPCU_OP_NONE      = 3'h0,
    CPCU_OP_READ      = 3'h1,
    CPCU_OP_WRITE     = 3'h2,
    CPCU_OP_ERASE     = 3'h3,
    CPCU_OP_ERASE_ALL = 3'h4,
    CPCU_OP_COMPARE   = 3'h5
  } cpcu_op_t;

  // Sequencer states, Gray along idle -> busy
  typedef enum logic [1:0] {
    CPCU_ST_IDLE = 2'b00,
    CPCU_ST_WAIT = 2'b01
  } cpcu_state_t;

  typedef struct packed {
    cpcu_op_t   op;
    logic [9:0] block;
    logic       skip_dep;    // Skip option and rating dependent data
  } cpcu_card_req_t;

  typedef struct packed {
    logic ok;
    logic mismatch;
    logic option_diff;
    logic rating_diff;
  } cpcu_card_rsp_t;

  typedef struct packed {
    logic [2:0]  ftype;
    logic [13:0] version;
    logic [31:0] checksum;
  } cpcu_hdr_t;

endpackage

// [logic/cpcu_top.sv]
// Card parameter command unit: decodes command codes written over APB,
// runs card operations, raises trips and shows block header fields.
// Assumes a card controller that answers each request with one rsp pulse
// and returns the header of the block named by hdr_sel combinationally.

// Contract
// - Compare code 8yyy compares block; command returns to zero on match.
// - Compare mismatch raises the compare trip.
// - Code 7yyy erases only block yyy.
// - Code 9999 erases all blocks at once.
// - Loading with differing option modules raises the option trip.
// - Loading from a different rating raises the rating trip.
// - Suppression flag blocks those two trips and skips dependent data.
// - Code 9666 sets suppression flag, 9555 clears it.
// - Write or erase under read-only raises the read-only trip.
// - Under read-only only 6yyy and 9777 act.
// - Code 9888 sets read-only flag, 9777 clears it.
// - Each block header holds number, type, version, checksum.
// - Header fields follow block select; empty card forces select zero.
// - Last-loaded shows last read block; defaults reload clears it.
// - File type codes 0 to 6.
// - File version is unsigned, limited to 9999.
// - Checksum is a signed 32-bit value.
// - Cloning selector codes 0 to 4.
// - Cloning values 1 and 2 are not saved; 3 and 4 are.
// - Failed card read, write or erase raises the card trip.
// - Trailing three digits give block 1 to 999.
// - Read copies block to working and non-volatile memory.
module cpcu_top
  import cpcu_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      card_req_valid,
  output cpcu_card_req_t            card_req,
  input  wire logic                 card_rsp_valid,
  input  wire cpcu_card_rsp_t       card_rsp,
  input  wire logic                 card_empty,
  output logic      [9:0]           hdr_sel,
  input  wire cpcu_hdr_t            hdr_in,
  output logic      [CPCU_TRIP_N-1:0] trips,
  output logic                      clone_save,
  output logic      [2:0]           clone_save_value
);

  // Registers
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic [13:0]            cmd_ff;
  logic [9:0]             last_load_ff;
  logic [9:0]             hdr_sel_ff;
  logic [2:0]             ftype_ff;
  logic [13:0]            fver_ff;
  logic [31:0]            fchk_ff;
  logic [2:0]             clone_ff;
  logic                   ro_ff;
  logic                   supp_ff;
  logic [CPCU_TRIP_N-1:0] trip_ff;
  logic                   clone_save_ff;
  logic [2:0]             clone_val_ff;
  logic                   req_valid_ff;
  cpcu_card_req_t         req_ff;
  cpcu_state_t            state_ff;

  // Decode signals
  logic                   wr_access;
  logic                   rd_setup;
  logic                   addr_hit;
  logic                   cmd_wr;
  logic [13:0]            wcode;
  logic [3:0]             wclass;
  logic [9:0]             wblock;
  logic                   is_whole;
  logic                   blk_ok;
  cpcu_op_t               nxt_op;
  logic                   ro_block;
  logic                   ro_trip;
  logic                   done;
  logic [CPCU_TRIP_N-1:0] trip_set;
  logic [CPCU_TRIP_N-1:0] trip_clr;

  // Leading digit of a four-digit code
  function automatic logic [3:0] cpcu_class(input logic [13:0] c);
    cpcu_class = 4'h0;
    for (int i = 1; i < 10; i++)
    begin
      if (int'(c) >= i * CPCU_CLASS_STEP)
        cpcu_class = 4'(i);
    end
  endfunction

  // APB phase decode
  assign wr_access = psel && penable && pready_ff && pwrite;
  assign rd_setup  = psel && !penable && !pready_ff;
  assign addr_hit  = (paddr <= CPCU_OFS_CONTROL) && (paddr[1:0] == 2'b00);
  assign cmd_wr    = wr_access && (paddr == CPCU_OFS_COMMAND)
                     && (pwdata[13:0] <= CPCU_CODE_MAX) && (pwdata[31:14] == 18'h0_0000)
                     && (state_ff == CPCU_ST_IDLE);

  assign wcode    = pwdata[13:0];
  assign wclass   = cpcu_class(wcode);
  assign wblock   = 10'(wcode - 14'(int'(wclass) * CPCU_CLASS_STEP));
  assign is_whole = (wcode == CPCU_CODE_ERASE_ALL) || (wcode == CPCU_CODE_SUPP_SET)
                    || (wcode == CPCU_CODE_SUPP_CLR) || (wcode == CPCU_CODE_RO_SET)
                    || (wcode == CPCU_CODE_RO_CLR);
  assign blk_ok   = (wblock != 10'h000) && (wblock <= CPCU_BLOCK_MAX);

  // Operation selected by the written code
  always_comb
  begin
    nxt_op = CPCU_OP_NONE;
    if (wcode == CPCU_CODE_ERASE_ALL)
      nxt_op = CPCU_OP_ERASE_ALL;
    else if (!is_whole && blk_ok)
    begin
      unique case (wclass)
        CPCU_CLASS_READ:    nxt_op = CPCU_OP_READ;
        CPCU_CLASS_WRITE:   nxt_op = CPCU_OP_WRITE;
        CPCU_CLASS_ERASE:   nxt_op = CPCU_OP_ERASE;
        CPCU_CLASS_COMPARE: nxt_op = CPCU_OP_COMPARE;
        default:            nxt_op = CPCU_OP_NONE;
      endcase
    end
  end

  assign ro_block = ro_ff && (nxt_op != CPCU_OP_READ) && (wcode != CPCU_CODE_RO_CLR);
  assign ro_trip  = cmd_wr && ro_ff && ((nxt_op == CPCU_OP_WRITE)
                    || (nxt_op == CPCU_OP_ERASE) || (nxt_op == CPCU_OP_ERASE_ALL));
  assign done     = (state_ff == CPCU_ST_WAIT) && card_rsp_valid;

  // APB answer: no wait state, read data registered in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= rd_setup;
      pslverr_ff <= rd_setup && !addr_hit;
      if (rd_setup)
      begin
        unique case (paddr)
          CPCU_OFS_COMMAND:   prdata_ff <= {18'h0_0000, cmd_ff};
          CPCU_OFS_LAST_LOAD: prdata_ff <= {22'h00_0000, last_load_ff};
          CPCU_OFS_HDR_SEL:   prdata_ff <= {22'h00_0000, hdr_sel_ff};
          CPCU_OFS_FTYPE:     prdata_ff <= {29'h0000_0000, ftype_ff};
          CPCU_OFS_FVERSION:  prdata_ff <= {18'h0_0000, fver_ff};
          CPCU_OFS_FCHKSUM:   prdata_ff <= fchk_ff;
          CPCU_OFS_CLONE_SEL: prdata_ff <= {29'h0000_0000, clone_ff};
          CPCU_OFS_STATUS:    prdata_ff <= {23'h00_0000, card_empty,
                                            state_ff == CPCU_ST_WAIT, supp_ff, ro_ff, trip_ff};
          default:            prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sequencer and card request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff     <= CPCU_ST_IDLE;
      req_valid_ff <= 1'b0;
      req_ff       <= '0;
    end
    else
    begin
      unique case (state_ff)
        CPCU_ST_IDLE:
        begin
          if (cmd_wr && !ro_block && (nxt_op != CPCU_OP_NONE))
          begin
            state_ff       <= CPCU_ST_WAIT;
            req_valid_ff   <= 1'b1;
            req_ff.op      <= nxt_op;
            req_ff.block   <= (nxt_op == CPCU_OP_ERASE_ALL) ? 10'h000 : wblock;
            req_ff.skip_dep <= supp_ff;
          end
        end
        CPCU_ST_WAIT:
        begin
          if (card_rsp_valid)
          begin
            state_ff     <= CPCU_ST_IDLE;
            req_valid_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // Command parameter: cleared on success
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_ff <= CPCU_RST_COMMAND;
    else if (cmd_wr)
      cmd_ff <= (is_whole && !ro_block) ? CPCU_RST_COMMAND : wcode;
    else if (done && card_rsp.ok && !card_rsp.mismatch)
      cmd_ff <= CPCU_RST_COMMAND;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ro_ff   <= 1'b0;
      supp_ff <= 1'b0;
    end
    else if (cmd_wr && !ro_block)
    begin
      if (wcode == CPCU_CODE_RO_SET)
        ro_ff <= 1'b1;
      else if (wcode == CPCU_CODE_RO_CLR)
        ro_ff <= 1'b0;
      if (wcode == CPCU_CODE_SUPP_SET)
        supp_ff <= 1'b1;
      else if (wcode == CPCU_CODE_SUPP_CLR)
        supp_ff <= 1'b0;
    end
  end

  // Trip causes from the card answer and the read-only gate
  always_comb
  begin
    trip_set = '0;
    trip_clr = '0;
    if (wr_access && (paddr == CPCU_OFS_CONTROL))
      trip_clr = pwdata[CPCU_TRIP_N-1:0];
    trip_set[CPCU_TRIP_RO] = ro_trip;
    if (done)
    begin
      trip_set[CPCU_TRIP_COMPARE] = (req_ff.op == CPCU_OP_COMPARE) && card_rsp.mismatch;
      trip_set[CPCU_TRIP_CARD]    = !card_rsp.ok && (req_ff.op != CPCU_OP_COMPARE);
      trip_set[CPCU_TRIP_OPTION]  = (req_ff.op == CPCU_OP_READ) && card_rsp.option_diff
                                    && !req_ff.skip_dep;
      trip_set[CPCU_TRIP_RATING]  = (req_ff.op == CPCU_OP_READ) && card_rsp.rating_diff
                                    && !req_ff.skip_dep;
    end
  end

  // Sticky trips, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trip_ff <= CPCU_RST_TRIPS;
    else
      trip_ff <= (trip_ff & ~trip_clr) | trip_set;
  end

  // last block read successfully; a read wins over the reload clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_load_ff <= CPCU_RST_BLOCK;
    else if (done && card_rsp.ok && (req_ff.op == CPCU_OP_READ))
      last_load_ff <= req_ff.block;
    else if (wr_access && (paddr == CPCU_OFS_CONTROL) && pwdata[CPCU_CTL_RELOAD])
      last_load_ff <= CPCU_RST_BLOCK;
  end

  // block select, forced to zero on empty card
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hdr_sel_ff <= CPCU_RST_BLOCK;
    else if (card_empty)
      hdr_sel_ff <= CPCU_RST_BLOCK;
    else if (wr_access && (paddr == CPCU_OFS_HDR_SEL) && (pwdata[9:0] <= CPCU_BLOCK_MAX))
      hdr_sel_ff <= pwdata[9:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ftype_ff <= 3'h0;
      fver_ff  <= 14'h0000;
      fchk_ff  <= 32'h0000_0000;
    end
    else
    begin
      ftype_ff <= (hdr_in.ftype <= CPCU_FTYPE_MAX) ? hdr_in.ftype : 3'h0;
      fver_ff  <= (hdr_in.version <= CPCU_FVER_MAX) ? hdr_in.version : CPCU_FVER_MAX;
      fchk_ff  <= hdr_in.checksum;
    end
  end

  // save only values other than 1 and 2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clone_ff      <= CPCU_RST_CLONE;
      clone_save_ff <= 1'b0;
      clone_val_ff  <= CPCU_RST_CLONE;
    end
    else
    begin
      clone_save_ff <= 1'b0;
      if (wr_access && (paddr == CPCU_OFS_CLONE_SEL) && (pwdata[2:0] <= CPCU_CLONE_MAX)
          && (pwdata[31:3] == 29'h0000_0000))
      begin
        clone_ff <= pwdata[2:0];
        if ((pwdata[2:0] != CPCU_CLONE_READ) && (pwdata[2:0] != CPCU_CLONE_PROG))
        begin
          clone_save_ff <= 1'b1;
          clone_val_ff  <= pwdata[2:0];
        end
      end
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign card_req_valid   = req_valid_ff;
  assign card_req         = req_ff;
  assign hdr_sel          = hdr_sel_ff;
  assign trips            = trip_ff;
  assign clone_save       = clone_save_ff;
  assign clone_save_value = clone_val_ff;

  // Checks
  AST_COMPARE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    done && req_ff.op == CPCU_OP_COMPARE && card_rsp.ok && !card_rsp.mismatch
    |=> cmd_ff == CPCU_RST_COMMAND)
    else $error("compare match did not clear command");
  AST_COMPARE_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    done && req_ff.op == CPCU_OP_COMPARE && card_rsp.mismatch
    |=> trip_ff[CPCU_TRIP_COMPARE])
    else $error("compare mismatch without trip");
  AST_ERASE_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && !ro_ff && wclass == CPCU_CLASS_ERASE && blk_ok && !is_whole
    |=> card_req_valid && card_req.op == CPCU_OP_ERASE && card_req.block == $past(wblock))
    else $error("erase block request wrong");
  AST_ERASE_ALL: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && !ro_ff && wcode == CPCU_CODE_ERASE_ALL
    |=> card_req_valid && card_req.op == CPCU_OP_ERASE_ALL)
    else $error("erase all not issued");
  AST_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn)
    done && req_ff.skip_dep |=> !$rose(trip_ff[CPCU_TRIP_OPTION])
    && !$rose(trip_ff[CPCU_TRIP_RATING]))
    else $error("suppressed trip raised");
  AST_RO_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && ro_ff && nxt_op == CPCU_OP_WRITE |=> trip_ff[CPCU_TRIP_RO] && !card_req_valid)
    else $error("read-only write not trapped");
  AST_RO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && wcode == CPCU_CODE_RO_SET && !ro_ff |=> ro_ff ##1 ro_ff || !$past(cmd_wr))
    else $error("read-only flag not set");
  AST_EMPTY_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    card_empty [*2] |-> hdr_sel_ff == CPCU_RST_BLOCK)
    else $error("block select not zero on empty card");
  AST_LAST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    done && card_rsp.ok && req_ff.op == CPCU_OP_READ |=> last_load_ff == $past(req_ff.block))
    else $error("last loaded block not updated");
  AST_CLONE_SAVE: assert property (@(posedge pclk) disable iff (!presetn)
    clone_save_ff |-> clone_val_ff != CPCU_CLONE_READ && clone_val_ff != CPCU_CLONE_PROG)
    else $error("cloning value 1 or 2 saved");
  AST_CARD_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    done && !card_rsp.ok && req_ff.op != CPCU_OP_COMPARE |=> trip_ff[CPCU_TRIP_CARD])
    else $error("card trip missing");

endmodule

// [tb/cpcu_card_model.sv]
// Behavioural card model: answers requests after a set delay, shows headers.
// Assumes one outstanding request, held until the answer pulse is seen.
module cpcu_card_model
  import cpcu_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           card_req_valid,
  input  wire cpcu_card_req_t card_req,
  input  wire cpcu_card_rsp_t rsp_set,
  input  wire logic [2:0]     dly,
  input  wire logic [9:0]     hdr_sel,
  output logic                card_rsp_valid,
  output cpcu_card_rsp_t      card_rsp,
  output cpcu_hdr_t           hdr_in,
  output cpcu_card_req_t      seen,
  output logic [15:0]         reqs
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] cnt_ff;
  logic       done_ff;

  // Answer once per request; answer lines toggle when not qualified
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff         <= 3'h0;
      done_ff        <= 1'b0;
      card_rsp_valid <= 1'b0;
      card_rsp       <= '0;
      seen           <= '0;
      reqs           <= 16'h0000;
    end
    else
    begin
      card_rsp_valid <= 1'b0;
      card_rsp       <= ~card_rsp;
      if (!card_req_valid)
      begin
        cnt_ff  <= 3'h0;
        done_ff <= 1'b0;
      end
      else if (!done_ff && cnt_ff == dly)
      begin
        card_rsp_valid <= 1'b1;
        card_rsp       <= rsp_set;
        done_ff        <= 1'b1;
        seen           <= card_req;
        reqs           <= reqs + 16'h0001;
      end
      else if (!done_ff)
        cnt_ff <= cnt_ff + 3'h1;
    end
  end

  assign hdr_in = '{ftype: hdr_sel[2:0], version: {hdr_sel, 4'h0},
                    checksum: {hdr_sel, 22'h0} ^ 32'ha5a5_5a5a};
endmodule

// [tb/card_param_command_unit_tb.sv]
// Self-checking bench for the card parameter command unit over APB.
// Assumes the card model in cpcu_card_model on the card side.
module card_param_command_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpcu_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic card_req_valid, card_rsp_valid, card_empty, clone_save;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, e_cmd, rd;
  cpcu_card_req_t card_req, seen;
  cpcu_card_rsp_t card_rsp, rsp_set;
  cpcu_hdr_t hdr_in;
  logic [9:0] hdr_sel, e_last, e_sel;
  logic [4:0] trips, e_trips;
  logic [2:0] clone_save_value, dly, save_val;
  logic [15:0] reqs, e_reqs;
  logic e_supp, e_ro, er;
  int miscompares, checks_done, saves;

  cpcu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_req_valid(card_req_valid), .card_req(card_req),
    .card_rsp_valid(card_rsp_valid), .card_rsp(card_rsp), .card_empty(card_empty),
    .hdr_sel(hdr_sel), .hdr_in(hdr_in), .trips(trips), .clone_save(clone_save),
    .clone_save_value(clone_save_value));

  cpcu_card_model card (.pclk(pclk), .presetn(presetn), .card_req_valid(card_req_valid),
    .card_req(card_req), .rsp_set(rsp_set), .dly(dly), .hdr_sel(hdr_sel),
    .card_rsp_valid(card_rsp_valid), .card_rsp(card_rsp), .hdr_in(hdr_in),
    .seen(seen), .reqs(reqs));

  // Clock, watchdog and save-pulse monitor
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  always @(posedge pclk)
  begin
    if (clone_save === 1'b1)
    begin
      saves    <= saves + 1;
      save_val <= clone_save_value;
    end
  end

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp32(rd, exp);
  endtask

  // Expected header field f of block s
  function automatic logic [31:0] hx(input logic [9:0] s, input int f);
    logic [13:0] v;
    v = {s, 4'h0};
    case (f)
      0: hx = (s[2:0] > CPCU_FTYPE_MAX) ? 32'h0 : 32'(s[2:0]);
      1: hx = (v > CPCU_FVER_MAX) ? 32'(CPCU_FVER_MAX) : 32'(v);
      default: hx = {s, 22'h0} ^ 32'ha5a5_5a5a;
    endcase
  endfunction

  // Issue a command code, wait for the card, check request, status, trips, last load and, for valid codes, command
  task automatic cmd(input int c, input logic [3:0] r);
    int cls, blk;
    logic act, chk;
    cpcu_op_t op;
    cls = c / 1000;
    blk = c % 1000;
    act = 1'b0;
    chk = 1'b1;
    op  = CPCU_OP_NONE;
    rsp_set <= cpcu_card_rsp_t'(r);
    dly     <= 3'($urandom_range(0, 4));
    apb(1'b1, CPCU_OFS_COMMAND, 32'(c));
    do
    begin
      apb(1'b0, CPCU_OFS_STATUS, 32'h0);
    end
    while (rd[CPCU_ST_BUSY] !== 1'b0);
    e_cmd = 32'(c);
    // read-only gate, blocked codes stay shown
    if (e_ro && c <= 9999 && cls != 6 && c != 9777)
      e_trips[CPCU_TRIP_RO] |= (c == 9999) || ((cls == 4 || cls == 7) && blk != 0);
    else if (c == 9666 || c == 9555 || c == 9888 || c == 9777 || c == 9999)
    begin
      e_cmd = 32'h0;
      if (c == 9666) e_supp = 1'b1;
      if (c == 9555) e_supp = 1'b0;
      if (c == 9888) e_ro = 1'b1;
      if (c == 9777) e_ro = 1'b0;
      if (c == 9999) op = CPCU_OP_ERASE_ALL;
    end
    else if (blk == 0 || !(cls inside {4, 6, 7, 8}))
      chk = 1'b0;
    else
      op = (cls == 4) ? CPCU_OP_WRITE : (cls == 6) ? CPCU_OP_READ :
           (cls == 7) ? CPCU_OP_ERASE : CPCU_OP_COMPARE;
    if (op != CPCU_OP_NONE)
    begin
      e_reqs++;
      cmp32(32'(seen.op), 32'(op));
      if (op != CPCU_OP_ERASE_ALL) cmp32(32'(seen.block), 32'(blk));
      cmp32(32'(seen.skip_dep), 32'(e_supp));
      if (op != CPCU_OP_ERASE_ALL) e_cmd = (r[3] && !r[2]) ? 32'h0 : 32'(c);
      if (op == CPCU_OP_COMPARE) e_trips[CPCU_TRIP_COMPARE] |= r[2];
      else e_trips[CPCU_TRIP_CARD] |= !r[3];
      if (op == CPCU_OP_READ && r[3]) e_last = 10'(blk);
      if (op == CPCU_OP_READ && !e_supp) e_trips[CPCU_TRIP_OPTION] |= r[1];
      if (op == CPCU_OP_READ && !e_supp) e_trips[CPCU_TRIP_RATING] |= r[0];
    end
    cmp32(32'(reqs), 32'(e_reqs));
    if (chk) rdc(CPCU_OFS_COMMAND, e_cmd);
    rdc(CPCU_OFS_STATUS, {23'h0, card_empty, 1'b0, e_supp, e_ro, e_trips});
    cmp32(32'(trips), 32'(e_trips));
    rdc(CPCU_OFS_LAST_LOAD, 32'(e_last));
  endtask

  int cl[] = '{6005, 6010, 6011, 6000, 10000, 9666, 6012, 9555, 8020, 8021, 7003,
               9999, 6030, 4001, 9888, 4002, 7004, 8005, 9999, 6006, 9777};
  logic [3:0] rs[] = '{8, 10, 9, 8, 8, 8, 11, 8, 8, 12, 8, 8, 0, 0, 8, 8, 8, 8, 8, 8, 8};
  logic [3:0] rr[] = '{8, 0, 12, 10, 9};
  int cx[] = '{4, 6, 7, 8};
  logic [2:0] ev;

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, card_empty, rsp_set, dly} = '0;
    {e_cmd, e_last, e_sel, e_trips, e_supp, e_ro, e_reqs, ev} = '0;
    {miscompares, checks_done, saves} = '0;
    presetn = 1'b0;
    void'($urandom(32'ha832));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), (i == 5) ? hx(10'h000, 2) : 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    cmp32({rd[30:0], er}, 32'h1);
    apb(1'b1, CPCU_OFS_LAST_LOAD, 32'h0000_03ff);
    rdc(CPCU_OFS_LAST_LOAD, 32'h0);
    for (int v = 0; v < 8; v++)
    begin
      n_saves_chk(v);
    end
    for (int i = 0; i < 10; i++)
    begin
      automatic int s = (i == 0) ? 999 : (i == 1) ? 1000 : $urandom_range(1, 998);
      apb(1'b1, CPCU_OFS_HDR_SEL, 32'(s));
      if (s <= 999) e_sel = 10'(s);
      rdc(CPCU_OFS_HDR_SEL, 32'(e_sel));
      cmp32(32'(hdr_sel), 32'(e_sel));
      rdc(CPCU_OFS_FTYPE, hx(e_sel, 0));
      rdc(CPCU_OFS_FVERSION, hx(e_sel, 1));
      rdc(CPCU_OFS_FCHKSUM, hx(e_sel, 2));
    end
    apb(1'b1, CPCU_OFS_HDR_SEL, 32'h0);
    card_empty <= 1'b1;
    apb(1'b1, CPCU_OFS_HDR_SEL, 32'h5);
    rdc(CPCU_OFS_HDR_SEL, 32'h0);
    card_empty <= 1'b0;
    foreach (cl[i]) cmd(cl[i], rs[i]);
    for (int i = 0; i < 8; i++)
      cmd(cx[$urandom_range(0, 3)] * 1000 + $urandom_range(1, 999), rr[$urandom_range(0, 4)]);
    apb(1'b1, CPCU_OFS_CONTROL, 32'h0000_011f);
    e_trips = '0;
    e_last  = '0;
    rdc(CPCU_OFS_STATUS, 32'h0);
    rdc(CPCU_OFS_LAST_LOAD, 32'h0);
    give_verdict();
  end

  // Cloning selector write: stored if legal, saved only for 0, 3 and 4
  task automatic n_saves_chk(input int v);
    int s0;
    s0 = saves;
    apb(1'b1, CPCU_OFS_CLONE_SEL, 32'(v));
    if (v <= 4) ev = 3'(v);
    rdc(CPCU_OFS_CLONE_SEL, 32'(ev));
    cmp32(32'(saves - s0), 32'(v == 0 || v == 3 || v == 4));
    if (v == 3 || v == 4) cmp32(32'(save_val), 32'(v));
  endtask
endmodule
